/* File: core/ssc_pkg.sv */
// Constants and types for the serial frame CRC and reply logic
package ssc_pkg;

	// ==========================================================
	// Frame layout
	localparam int          FRAME_W        = 32;
	localparam int          CRC_W          = 5;
	localparam int          CRC_SPAN       = 26;
	localparam int          CNT_W          = 6;
	localparam int          POS_START      = 31;
	localparam int          POS_RW         = 30;
	localparam int          POS_ADDR_HI    = 29;
	localparam int          POS_ADDR_LO    = 25;
	localparam int          POS_PREV_HI    = 30;
	localparam int          POS_PREV_LO    = 26;
	localparam int          POS_FCNT_HI    = 25;
	localparam int          POS_FCNT_LO    = 23;
	localparam int          POS_STAT_HI    = 22;
	localparam int          POS_DATA_HI    = 21;
	localparam int          POS_DATA_LO    = 6;
	localparam int          POS_STAT_LO    = 5;
	localparam int          POS_SPAN_LO    = 5;
	localparam int          IER_BIT        = 15;

	// ==========================================================
	// Values
	localparam logic [4:0]  CRC_SEED       = 5'h1F;
	localparam logic [31:0] POWER_ON_FRAME = 32'h80400021;
	localparam logic [4:0]  ADDR_BAD       = 5'h11;
	localparam logic [4:0]  ADDR_WRITE     = 5'h10;
	localparam logic [4:0]  ADDR_ERR       = 5'h0F;
	localparam logic [5:0]  BITS_FULL      = 6'h20;

	// Kind of reply that the next frame carries
	typedef enum logic [1:0] {
		KIND_READ  = 2'b00,
		KIND_WRITE = 2'b01,
		KIND_BAD   = 2'b11
	} ssc_kind_t;

endpackage : ssc_pkg

/* File: core/ssc_crc_if.sv */
// Carrier between the frame logic and a CRC generator
`timescale 1ns/1ps
interface ssc_crc_if;
	logic [ssc_pkg::CRC_SPAN-1:0] bits;
	logic [ssc_pkg::CRC_W-1:0]    crc;

	modport calc (input bits, output crc);
	modport user (output bits, input crc);
endinterface : ssc_crc_if

/* File: core/ssc_crc5.sv */
// Combinational 5-bit CRC over the 26 covered frame bits, MSB first
`timescale 1ns/1ps
module ssc_crc5 (
	ssc_crc_if.calc port_i
);
	import ssc_pkg::*;

	always_comb begin
		logic [4:0] c;
		logic       d;
		c = CRC_SEED;                           // R1
		d = 1'b0;
		for (int i = CRC_SPAN - 1; i >= 0; i--) begin   // R5
			d = port_i.bits[i];
			c = {c[3], c[2], c[1] ^ c[4] ^ d, c[0], c[4] ^ d};   // R6
		end
		port_i.crc = c;                         // R7
	end

endmodule : ssc_crc5

/* File: core/ssc_spi_frame.sv */
// Serial frame engine: CRC check and generation, special reply frames
`timescale 1ns/1ps
// Overview of operation
// R1: 5-bit CRC x^5+x^2+1, seeded all ones
// R2: Device appends CRC to every outgoing frame
// R3: Controller appends CRC to every incoming frame
// R4: Bad-CRC frames are dropped, no access
// R5: CRC covers bits 30..5, MSB first
// R6: Shift update per bit as fixed equations
// R7: Stage c4 is CRC most significant bit
// R8: Bad-CRC reply: address 0x11, error register data
// R9: Interface error hidden first, then reads set
// R10: Write reply: address 0x10, main angle data
// R11: Status flags high until angle ready, unlocked
// R12: First frame after reset is 0x80400021
// R13: Control register resets leave interface untouched
// R14: Bad-CRC reply status bits zero, counter filled
// R15: Bad-CRC data follows error register order
// R16: Incoming layout: start, rw, address, data, CRC
// R17: Reply layout with advancing 3-bit frame counter
// R18: Status is OR of errors, cleared after read
module ssc_spi_frame (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       cs_n,
	input  wire logic                       sclk,
	input  wire logic                       mosi,
	output logic                            miso,
	output logic                            miso_oe,
	input  wire logic [15:0]                angle_main,
	input  wire logic [15:0]                err_bits,
	input  wire logic                       err_active,
	input  wire logic                       err_locked,
	input  wire logic                       angle_ready,
	input  wire logic [15:0]                rd_data,
	output logic [4:0]                      rd_addr,
	output logic                            wr_en,
	output logic [4:0]                      wr_addr,
	output logic [15:0]                     wr_data,
	output logic [15:0]                     error_flags,
	output logic                            interface_error_flag
);
	import ssc_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [2:0] cs_sr;
	logic [2:0] sclk_sr;
	logic [1:0] mosi_sr;

	always_ff @(posedge clk) begin
		if (srst) begin
			cs_sr   <= 3'h7;
			sclk_sr <= 3'h7;
			mosi_sr <= 2'h0;
		end else begin
			cs_sr   <= {cs_sr[1:0], cs_n};
			sclk_sr <= {sclk_sr[1:0], sclk};
			mosi_sr <= {mosi_sr[0], mosi};
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic cs_low;
	logic sck_rise;
	logic sck_fall;
	assign cs_fall  = cs_sr[2] & ~cs_sr[1];
	assign cs_rise  = ~cs_sr[2] & cs_sr[1];
	assign cs_low   = ~cs_sr[1];
	assign sck_rise = cs_low & ~sclk_sr[2] & sclk_sr[1];
	assign sck_fall = cs_low & sclk_sr[2] & ~sclk_sr[1];

	// ==========================================================
	// State
	logic [31:0]     rx_r;
	logic [31:0]     tx_r;
	logic [5:0]      bits_r;
	logic [2:0]      fcnt_r;
	logic [4:0]      prev_r;
	ssc_kind_t       kind_r;
	logic            first_r;
	logic            power_on_r;
	logic            stat_r;
	logic            ier_r;
	logic            miso_r;
	logic            oe_r;
	logic            wr_en_r;
	logic [4:0]      wr_addr_r;
	logic [15:0]     wr_data_r;
	logic [15:0]     eflags_r;

	// ==========================================================
	// CRC generators
	ssc_crc_if rx_crc ();
	ssc_crc_if tx_crc ();

	ssc_crc5 u_rx_crc (
		.port_i (rx_crc.calc)
	);

	ssc_crc5 u_tx_crc (
		.port_i (tx_crc.calc)
	);

	logic frame_end;
	logic crc_ok;
	logic is_write;
	assign rx_crc.bits = rx_r[POS_RW:POS_SPAN_LO];                              // R5
	assign crc_ok      = (rx_crc.crc == rx_r[CRC_W-1:0]);                       // R4
	assign frame_end   = cs_rise & (bits_r == BITS_FULL);
	assign is_write    = rx_r[POS_RW];                                          // R16

	// ==========================================================
	// Reply frame assembly
	logic [15:0] err_word;
	logic [15:0] reply_data;
	logic [4:0]  reply_addr;
	logic        reply_stat;
	logic [31:0] body;
	logic [31:0] frame_w;

	assign err_word = {ier_r, err_bits[IER_BIT-1:0]};                          // R15

	always_comb begin
		reply_addr = prev_r;
		reply_data = (prev_r == ADDR_ERR) ? err_word : rd_data;
		reply_stat = power_on_r | stat_r;                                       // R11 R18
		case (kind_r)
			KIND_WRITE: begin
				reply_addr = ADDR_WRITE;                                            // R10
				reply_data = angle_main;                                            // R10
			end
			KIND_BAD: begin
				reply_addr = ADDR_BAD;                                              // R8
				reply_data = {1'b0, err_bits[IER_BIT-1:0]};                         // R9 R15
				reply_stat = 1'b0;                                                  // R14
			end
			default: reply_addr = prev_r;
		endcase
		body = {1'b1, reply_addr, fcnt_r, reply_stat, reply_data, reply_stat, 5'h00};  // R17
	end

	assign tx_crc.bits = body[POS_RW:POS_SPAN_LO];
	assign frame_w = first_r ? POWER_ON_FRAME : {body[31:5], tx_crc.crc};       // R2 R12

	// ==========================================================
	// Shift paths; srst stands for power-up or low power exit only
	always_ff @(posedge clk) begin
		if (srst) begin                                                         // R13
			rx_r   <= 32'h00000000;
			bits_r <= 6'h00;
		end else if (cs_fall) begin
			bits_r <= 6'h00;
		end else if (sck_rise) begin
			rx_r <= {rx_r[30:0], mosi_sr[1]};
			if (bits_r != 6'h3F)
				bits_r <= bits_r + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tx_r   <= 32'h00000000;
			miso_r <= 1'b0;
			oe_r   <= 1'b0;
		end else if (cs_fall) begin
			tx_r   <= frame_w;
			miso_r <= frame_w[POS_START];
			oe_r   <= 1'b1;
		end else if (sck_fall) begin
			miso_r <= tx_r[POS_START];
			tx_r   <= {tx_r[30:0], 1'b0};
		end else if (cs_rise) begin
			oe_r <= 1'b0;
		end
	end

	// ==========================================================
	// Frame decisions
	always_ff @(posedge clk) begin
		if (srst) begin
			kind_r    <= KIND_READ;
			prev_r    <= 5'h00;
			wr_en_r   <= 1'b0;
			wr_addr_r <= 5'h00;
			wr_data_r <= 16'h0000;
		end else begin
			wr_en_r <= 1'b0;
			if (frame_end) begin
				if (!crc_ok) begin
					kind_r <= KIND_BAD;                                             // R4 R8
				end else if (is_write) begin
					kind_r    <= KIND_WRITE;
					wr_en_r   <= 1'b1;
					wr_addr_r <= rx_r[POS_ADDR_HI:POS_ADDR_LO];
					wr_data_r <= rx_r[POS_DATA_HI:POS_DATA_LO];
				end else begin
					kind_r <= KIND_READ;
					prev_r <= rx_r[POS_ADDR_HI:POS_ADDR_LO];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			fcnt_r <= 3'h0;
		else if (cs_rise)
			fcnt_r <= fcnt_r + 3'h1;                                                // R17
	end

	always_ff @(posedge clk) begin
		if (srst)
			first_r <= 1'b1;
		else if (cs_fall)
			first_r <= 1'b0;                                                        // R12
	end

	always_ff @(posedge clk) begin
		if (srst)
			power_on_r <= 1'b1;
		else if (angle_ready && !err_locked)
			power_on_r <= 1'b0;                                                     // R11
	end

	// Set wins over clear for both sticky flags
	always_ff @(posedge clk) begin
		if (srst)
			ier_r <= 1'b0;
		else if (frame_end && !crc_ok)
			ier_r <= 1'b1;                                                          // R9
		else if (cs_fall && !first_r && kind_r == KIND_READ && prev_r == ADDR_ERR)
			ier_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst)
			stat_r <= 1'b0;
		else if (err_active || ier_r)
			stat_r <= 1'b1;                                                         // R18
		else if (cs_fall && !first_r && kind_r == KIND_READ)
			stat_r <= 1'b0;                                                         // R18
	end

	always_ff @(posedge clk) begin
		if (srst)
			eflags_r <= 16'h0000;
		else
			eflags_r <= err_word;
	end

	assign miso                 = miso_r;
	assign miso_oe              = oe_r;
	assign rd_addr              = prev_r;
	assign wr_en                = wr_en_r;
	assign wr_addr              = wr_addr_r;
	assign wr_data              = wr_data_r;
	assign error_flags          = eflags_r;
	assign interface_error_flag = ier_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_POWER_ON_FRAME: assert property (   // R13
		!first_r |=> !first_r)
		else $error("power-on frame armed again without reset");
	AST_FIRST_VALUE: assert property (   // R12
		cs_fall && first_r |=> tx_r == POWER_ON_FRAME && miso_r)
		else $error("power-on frame not loaded");
	AST_TX_CRC: assert property (   // R2
		cs_fall && !first_r |=> tx_r[4:0] == $past(tx_crc.crc))
		else $error("outgoing CRC wrong");
	AST_BAD_DROP: assert property (   // R4
		frame_end && !crc_ok |=> !wr_en_r && kind_r == KIND_BAD && ier_r)
		else $error("bad frame not dropped");
	AST_GOOD_WRITE: assert property (   // R16
		frame_end && crc_ok && is_write |=> wr_en_r ##1 !wr_en_r)
		else $error("write strobe not a single pulse");
	AST_BAD_REPLY: assert property (   // R8
		cs_fall && !first_r && kind_r == KIND_BAD |=>
		tx_r[30:26] == ADDR_BAD && !tx_r[21] && !tx_r[22] && !tx_r[5])
		else $error("bad CRC reply malformed");
	AST_WRITE_REPLY: assert property (   // R10
		cs_fall && !first_r && kind_r == KIND_WRITE |=>
		tx_r[30:26] == ADDR_WRITE && tx_r[21:6] == $past(angle_main))
		else $error("write reply malformed");
	AST_STATUS_PO: assert property (   // R11
		cs_fall && !first_r && power_on_r && kind_r != KIND_BAD |=> tx_r[22] && tx_r[5])
		else $error("status flags low during power-on");
	AST_FCNT: assert property (   // R17
		cs_rise |=> fcnt_r == $past(fcnt_r) + 3'h1)
		else $error("frame counter did not advance");
	COV_BAD: cover property (frame_end && !crc_ok);
	COV_WRITE: cover property (frame_end && crc_ok && is_write);
	COV_READ_ERR: cover property (cs_fall && kind_r == KIND_READ && prev_r == ADDR_ERR && ier_r);
endmodule : ssc_spi_frame

/* File: testbench/ssc_host_model.sv */
// Serial controller model facing the frame engine
`timescale 1ns/1ps
module ssc_host_model (
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// Frame check sequence, MSB first over bits 30..5
	function automatic logic [4:0] crc5(input logic [25:0] d);
		logic [4:0] c;
		c = 5'h1F;
		for (int i = 25; i >= 0; i--) begin
			c = {c[3], c[2], c[1] ^ c[4] ^ d[i], c[0], c[4] ^ d[i]};
		end
		return c;
	endfunction : crc5

	// ==========================================================
	// One 32-bit frame, clock idles high, 200 ns clock period
	task automatic send(input logic rw, input logic [4:0] a, input logic [15:0] d,
			input logic bad, output logic [31:0] rx);
		logic [31:0] f;
		f = {1'b0, rw, a, 3'h0, d, 1'b0, 5'h00};
		f[4:0] = crc5(f[30:5]) ^ {4'h0, bad};
		rx = 32'h0;
		cs_n = 1'b0;
		#100;
		for (int i = 31; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = f[i];
			#100;
			sclk = 1'b1;
			rx[i] = miso;
			#100;
		end
		// Released line shows the inverse of its last value
		mosi = ~mosi;
		cs_n = 1'b1;
		#400;
	endtask : send
endmodule : ssc_host_model

/* File: testbench/spi_frame_crc_and_response_tb_top.sv */
// Self-checking bench for the serial frame engine
`timescale 1ns/1ps
module spi_frame_crc_and_response_tb_top;
	import ssc_pkg::*;
	logic        clk, srst, cs_n, sclk, mosi, miso, miso_oe, wr_en;
	logic        err_active, err_locked, angle_ready, interface_error_flag;
	logic [15:0] angle_main, err_bits, rd_data, wr_data, error_flags;
	logic [4:0]  rd_addr, wr_addr;
	logic [31:0] rx;
	logic [2:0]  fcnt;
	int          n_fail, comparisons, n_wr;

	assign rd_data = {11'h0, rd_addr} ^ 16'hA500;

	ssc_spi_frame uut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .angle_main(angle_main), .err_bits(err_bits),
		.err_active(err_active), .err_locked(err_locked), .angle_ready(angle_ready),
		.rd_data(rd_data), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .error_flags(error_flags),
		.interface_error_flag(interface_error_flag));

	ssc_host_model u_host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wr_en === 1'b1) n_wr++;
	end

	// ==========================================================
	// Checking helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic frame(input logic rw, input logic [4:0] a, input logic [15:0] d,
			input logic bad);
		@(posedge clk);
		#1;
		fork
			u_host.send(rw, a, d, bad, rx);
			begin
				repeat (20) @(posedge clk);
				#1;
				check("miso enable in frame", miso_oe, 1'b1);
			end
		join
		check("miso enable idle", miso_oe, 1'b0);
	endtask : frame

	task automatic reply(input logic [4:0] prev, input logic [15:0] data);
		check("start", rx[31], 1'b1);
		check("prev", rx[30:26], prev);
		check("count", rx[25:23], fcnt);
		check("data", rx[21:6], data);
		check("crc", rx[4:0], u_host.crc5(rx[30:5]));
		fcnt++;
	endtask : reply

	task automatic test_done();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	// ==========================================================
	// Test sequence
	initial begin
		srst = 1'b1;
		angle_ready = 1'b0;
		err_locked = 1'b0;
		err_active = 1'b0;
		angle_main = 16'hBEEF;
		err_bits = 16'hDA5A;
		fcnt = 3'h0;
		repeat (8) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		check("power on frame", rx, POWER_ON_FRAME);
		fcnt++;
		frame(1'b0, ADDR_ERR, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status hi", rx[22], 1'b1);
		check("status lo", rx[5], 1'b1);
		@(posedge clk);
		#1 angle_ready = 1'b1;
		frame(1'b1, 5'h07, 16'h1234, 1'b1);
		reply(ADDR_ERR, {1'b0, err_bits[14:0]});
		check("status released", {rx[22], rx[5]}, 2'b00);
		check("bad frame write", n_wr, 0);
		check("flag", interface_error_flag, 1'b1);
		check("error flags", error_flags, {1'b1, err_bits[14:0]});
		frame(1'b0, ADDR_ERR, 16'h0000, 1'b0);
		reply(ADDR_BAD, {1'b0, err_bits[14:0]});
		check("bad status", {rx[22], rx[5]}, 2'b00);
		frame(1'b1, 5'h07, 16'h1234, 1'b0);
		reply(ADDR_ERR, {1'b1, err_bits[14:0]});
		check("status after error", rx[22], 1'b1);
		check("write count", n_wr, 1);
		check("write addr", wr_addr, 5'h07);
		check("write data", wr_data, 16'h1234);
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(ADDR_WRITE, angle_main);
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("read addr", rd_addr, 5'h03);
		// Second power-up in mid-run, with an error still locked
		@(posedge clk);
		#1 srst = 1'b1;
		err_locked = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		check("power on again", rx, POWER_ON_FRAME);
		fcnt = 3'h1;
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status locked", {rx[22], rx[5]}, 2'b11);
		@(posedge clk);
		#1 err_locked = 1'b0;
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status ready", {rx[22], rx[5]}, 2'b00);
		@(posedge clk);
		#1 err_active = 1'b1;
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status error", {rx[22], rx[5]}, 2'b11);
		@(posedge clk);
		#1 err_active = 1'b0;
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status presented", {rx[22], rx[5]}, 2'b11);
		frame(1'b0, 5'h03, 16'h0000, 1'b0);
		reply(5'h03, 16'hA503);
		check("status cleared", {rx[22], rx[5]}, 2'b00);
		test_done();
	end
endmodule : spi_frame_crc_and_response_tb_top
